/* File: hw/led_strap_params.svh */
// Offsets, field positions, reset values and timing counts of the lamp, strap and reset block.
`ifndef LED_STRAP_PARAMS_SVH
`define LED_STRAP_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define RESET_MIN_NS 1000
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLINK_HALF_MS 50
`define BLINK_HALF_CYCLES ((`BLINK_HALF_MS * 1000000) / `CLK_PERIOD_NS)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_PORT_CONTROL 8'h0c
`define CTRL_MODE3_EN 0
`define CTRL_DUPLEX_SEL 1
`define CTRL_IRQ_MODE 3
`define CTRL_IRQ_EN 5
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h00
`define EVT_LINK_CHG 0
`define EVT_SLEEP 2
`define EVT_RESET_DONE 4
`define EVT_WIDTH 5
`define MASK_RESET 5'h00
`define PCR_ADDR_A 0
`define PCR_ADDR_B 8
`define PCR_MODE 16
`define PCR_LAMP_POL 20
`define PIN_SYNC_RESET 14'h3001
`endif

/* File: hw/led_strap_pkg.sv */
// Types shared by the lamp, strap and reset block.
package led_strap_pkg;
  typedef struct packed {
    logic full_duplex;
    logic collision;
    logic rx_act;
    logic tx_act;
    logic speed_100;
    logic link_good;
  } port_status_t;
  typedef enum logic [2:0] {
    LED_MODE1 = 3'b001,
    LED_MODE2 = 3'b010,
    LED_MODE3 = 3'b100
  } led_mode_t;
endpackage : led_strap_pkg

/* File: hw/led_strap_reset_control.sv */
// Lamp drive, board reset, sleep/interrupt pins and strap latching for both ports.
//
// Behaviour
// - Two lamp modes come from a strap; the third only from a control register.
// - Each lamp's lit level is inverted when its pin was sensed pulled up.
// - Mode 1: link lamp lit while link is good, dark otherwise.
// - Modes 2 and 3: link lamp lit on good link, blinking while active.
// - Speed lamp lit at 100 Mb/s, dark at 10 Mb/s, in every mode.
// - Mode 1: third lamp lit while transmit or receive activity is present.
// - Mode 2 third lamp shows collision; mode 3 may show full duplex instead.
// - Board reset held low 1 us or more resets all registers to defaults.
// - Strap pins are sampled during every reset and set the operating modes.
// - By default the sleep pin is an active-low input requesting power-down.
// - In interrupt mode the sleep pin is open drain, pulled low on enabled interrupt.
// - Four straps give address bits 4 to 1; bit 0 tells port A from B.
// - Port A takes even addresses 0 to 30, port B the next odd ones.
// - Address straps read as zero when left open, thanks to weak pull-downs.
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "led_strap_params.svh"
module led_strap_reset_control
  import led_strap_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire port_status_t port_a_status_i,
  input wire port_status_t port_b_status_i,
  input wire logic [1:0] irq_cond_i,
  input wire logic board_reset_n_i,
  input wire logic led_mode_strap_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  input wire logic addr_strap_bit3_i,
  input wire logic addr_strap_bit4_i,
  input wire logic port_a_link_lamp_i,
  output logic port_a_link_lamp_o,
  output logic port_a_link_lamp_oe_o,
  input wire logic port_a_speed_lamp_i,
  output logic port_a_speed_lamp_o,
  output logic port_a_speed_lamp_oe_o,
  input wire logic port_a_activity_collision_lamp_i,
  output logic port_a_activity_collision_lamp_o,
  output logic port_a_activity_collision_lamp_oe_o,
  input wire logic port_b_link_lamp_i,
  output logic port_b_link_lamp_o,
  output logic port_b_link_lamp_oe_o,
  input wire logic port_b_speed_lamp_i,
  output logic port_b_speed_lamp_o,
  output logic port_b_speed_lamp_oe_o,
  input wire logic port_b_activity_collision_lamp_i,
  output logic port_b_activity_collision_lamp_o,
  output logic port_b_activity_collision_lamp_oe_o,
  input wire logic port_a_sleep_irq_pin_i,
  output logic port_a_sleep_irq_pin_o,
  output logic port_a_sleep_irq_pin_oe_o,
  input wire logic port_b_sleep_irq_pin_i,
  output logic port_b_sleep_irq_pin_o,
  output logic port_b_sleep_irq_pin_oe_o,
  output logic [1:0] sleep_o,
  output logic [4:0] port_a_addr_o,
  output logic [4:0] port_b_addr_o
);

  localparam int unsigned NPIN = 14;
  localparam logic [7:0] RESET_MIN = 8'(`RESET_MIN_CYCLES);
  localparam logic [NPIN-1:0] PIN_RESET = `PIN_SYNC_RESET;

  if (BLINK_HALF_CYCLES < 2) begin : g_bad_blink
    $error("BLINK_HALF_CYCLES must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and three agree.

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic [NPIN-1:0] pin_s3_reg;
  logic [NPIN-1:0] pin_filt_reg;

  assign pin_raw = {port_b_sleep_irq_pin_i, port_a_sleep_irq_pin_i,
                    port_b_activity_collision_lamp_i, port_b_speed_lamp_i, port_b_link_lamp_i,
                    port_a_activity_collision_lamp_i, port_a_speed_lamp_i, port_a_link_lamp_i,
                    addr_strap_bit4_i, addr_strap_bit3_i, addr_strap_bit2_i, addr_strap_bit1_i,
                    led_mode_strap_i, board_reset_n_i};

  always_ff @(posedge clk_i) begin
    pin_s1_reg <= pin_raw;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
  end

  // Straps take the agreed level one edge ahead of the filter, so a short reset still sees them.
  logic [NPIN-1:0] pin_next;
  assign pin_next = (pin_s2_reg & pin_s3_reg) | (pin_filt_reg & (pin_s2_reg | pin_s3_reg));
  for (genvar i = 0; i < NPIN; i++) begin : g_filt
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_filt_reg[i] <= PIN_RESET[i];
      end else begin
        pin_filt_reg[i] <= pin_next[i];
      end
    end
  end

  logic rstn_filt;
  logic mode_pin;
  logic [3:0] addr_pin;
  logic [5:0] lamp_pin;
  logic [1:0] sleep_pin;
  assign rstn_filt = pin_filt_reg[0];
  assign mode_pin = pin_next[1];
  assign addr_pin = pin_next[5:2];
  assign lamp_pin = pin_next[11:6];
  assign sleep_pin = pin_filt_reg[13:12];

  //////////////////////////////////////////////////////////////////////////////
  // Board reset: a short glitch on the pin is ignored, a long low resets everything.

  logic [7:0] low_cnt_reg;
  logic dev_rst_reg;
  logic dev_rst_d_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || rstn_filt) begin
      low_cnt_reg <= 8'h00;
    end else if (low_cnt_reg != RESET_MIN) begin
      low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    dev_rst_reg <= rst_i || (!rstn_filt && low_cnt_reg == RESET_MIN);
    dev_rst_d_reg <= dev_rst_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap latches follow the pins throughout reset and freeze at its release.

  logic mode_strap_reg;
  logic [3:0] addr_strap_reg;
  logic [5:0] lamp_pol_reg;

  // Lamp drivers are off during reset, so the lamp pins show only their pull resistors.
  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      mode_strap_reg <= mode_pin;
      addr_strap_reg <= addr_pin;
      lamp_pol_reg <= lamp_pin;
    end
  end

  assign port_a_addr_o = {addr_strap_reg, 1'b0};
  assign port_b_addr_o = {addr_strap_reg, 1'b1};

  //////////////////////////////////////////////////////////////////////////////
  // Registers over classic Wishbone; one wait state, ack falls after one cycle.

  logic [`CTRL_WIDTH-1:0] ctrl_reg;
  logic [`EVT_WIDTH-1:0] status_reg;
  logic [`EVT_WIDTH-1:0] mask_reg;
  logic [`EVT_WIDTH-1:0] evt;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic req;
  logic wr_done;
  logic rd_status;
  led_mode_t mode;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_done = req && ack_reg && wb_we_i && wb_sel_i[0];
  assign rd_status = req && ack_reg && !wb_we_i && wb_adr_i == `OFS_STATUS;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      rdat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      unique case (wb_adr_i)
        `OFS_CTRL: rdat_reg <= 32'(ctrl_reg);
        `OFS_STATUS: rdat_reg <= 32'(status_reg);
        `OFS_MASK: rdat_reg <= 32'(mask_reg);
        `OFS_PORT_CONTROL: rdat_reg <= (32'(port_a_addr_o) << `PCR_ADDR_A)
          | (32'(port_b_addr_o) << `PCR_ADDR_B) | (32'(mode) << `PCR_MODE)
          | (32'(lamp_pol_reg) << `PCR_LAMP_POL);
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      ctrl_reg <= `CTRL_RESET;
    end else if (wr_done && wb_adr_i == `OFS_CTRL) begin
      ctrl_reg <= wb_dat_i[`CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      mask_reg <= `MASK_RESET;
    end else if (wr_done && wb_adr_i == `OFS_MASK) begin
      mask_reg <= wb_dat_i[`EVT_WIDTH-1:0];
    end
  end

  // A read clears the status, but an event in the same cycle survives it.
  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      status_reg <= '0;
    end else if (rd_status) begin
      status_reg <= evt;
    end else begin
      status_reg <= status_reg | evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_reg & mask_reg);
    end
  end

  // The strap picks mode 1 when high and mode 2 when low; only software reaches mode 3.
  always_comb begin
    if (ctrl_reg[`CTRL_MODE3_EN]) begin
      mode = LED_MODE3;
    end else if (mode_strap_reg) begin
      mode = LED_MODE1;
    end else begin
      mode = LED_MODE2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Blink phase from one shared divider; both ports blink in step.

  logic [31:0] blink_cnt_reg;
  logic blink_phase_reg;

  always_ff @(posedge clk_i) begin
    if (dev_rst_reg) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_phase_reg <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_HALF_CYCLES - 1)) begin
      blink_cnt_reg <= 32'h0000_0000;
      blink_phase_reg <= !blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-port lamps, sleep input and interrupt pin.

  port_status_t st [2];
  logic [5:0] lamp_out_reg;
  logic [1:0] sleep_out_oe_reg;
  logic [1:0] sleep_reg;
  logic [1:0] link_d_reg;

  assign st[0] = port_a_status_i;
  assign st[1] = port_b_status_i;

  for (genvar p = 0; p < 2; p++) begin : g_port
    logic act;
    logic lit_link;
    logic lit_speed;
    logic lit_third;
    logic irq_mode;
    assign act = st[p].tx_act || st[p].rx_act;
    assign irq_mode = ctrl_reg[`CTRL_IRQ_MODE + p];

    always_comb begin
      lit_speed = st[p].speed_100;
      lit_link = 1'b0;
      lit_third = 1'b0;
      unique case (mode)
        LED_MODE1: begin
          lit_link = st[p].link_good;
          lit_third = act;
        end
        LED_MODE2: begin
          lit_link = st[p].link_good && !(act && blink_phase_reg);
          lit_third = st[p].collision;
        end
        LED_MODE3: begin
          lit_link = st[p].link_good && !(act && blink_phase_reg);
          lit_third = ctrl_reg[`CTRL_DUPLEX_SEL + p] ? st[p].full_duplex
                                                     : st[p].collision;
        end
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (dev_rst_reg) begin
        lamp_out_reg[3*p +: 3] <= 3'h0;
      end else begin
        lamp_out_reg[3*p +: 3] <= {lit_third, lit_speed, lit_link}
                                  ^ lamp_pol_reg[3*p +: 3];
      end
    end

    always_ff @(posedge clk_i) begin
      if (dev_rst_reg) begin
        sleep_reg[p] <= 1'b0;
        sleep_out_oe_reg[p] <= 1'b0;
        link_d_reg[p] <= 1'b0;
      end else begin
        sleep_reg[p] <= !irq_mode && !sleep_pin[p];
        sleep_out_oe_reg[p] <= irq_mode && ctrl_reg[`CTRL_IRQ_EN + p]
                               && irq_cond_i[p];
        link_d_reg[p] <= st[p].link_good;
      end
    end

    assign evt[`EVT_LINK_CHG + p] = link_d_reg[p] != st[p].link_good && !dev_rst_d_reg;
    assign evt[`EVT_SLEEP + p] = !sleep_reg[p] && !irq_mode && !sleep_pin[p];
  end

  assign evt[`EVT_RESET_DONE] = dev_rst_d_reg && !dev_rst_reg;
  assign sleep_o = sleep_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive: lamps drive push-pull after reset, the sleep pin only ever pulls low.

  logic lamp_oe;
  assign lamp_oe = !dev_rst_reg;

  assign port_a_link_lamp_o = lamp_out_reg[0];
  assign port_a_speed_lamp_o = lamp_out_reg[1];
  assign port_a_activity_collision_lamp_o = lamp_out_reg[2];
  assign port_b_link_lamp_o = lamp_out_reg[3];
  assign port_b_speed_lamp_o = lamp_out_reg[4];
  assign port_b_activity_collision_lamp_o = lamp_out_reg[5];
  assign port_a_link_lamp_oe_o = lamp_oe;
  assign port_a_speed_lamp_oe_o = lamp_oe;
  assign port_a_activity_collision_lamp_oe_o = lamp_oe;
  assign port_b_link_lamp_oe_o = lamp_oe;
  assign port_b_speed_lamp_oe_o = lamp_oe;
  assign port_b_activity_collision_lamp_oe_o = lamp_oe;
  assign port_a_sleep_irq_pin_o = 1'b0;
  assign port_b_sleep_irq_pin_o = 1'b0;
  assign port_a_sleep_irq_pin_oe_o = sleep_out_oe_reg[0];
  assign port_b_sleep_irq_pin_oe_o = sleep_out_oe_reg[1];

endmodule : led_strap_reset_control

/* File: test/led_strap_board.sv */
// Board model: strapped lamp pins, pulled-up sleep pins and address strap resistors.
`timescale 1ns/10ps
module led_strap_board (
  input logic [5:0] lamp_i,
  input logic [5:0] lamp_oe_i,
  input logic [5:0] pull_up_i,
  output logic [5:0] lamp_pin_o,
  input logic [1:0] sleep_oe_i,
  input logic [1:0] sleep_low_i,
  output logic [1:0] sleep_pin_o,
  input logic [3:0] fit_i,
  output logic [3:0] strap_o
);
  // A released lamp pin rests at its strap resistor, which is what reset senses.
  assign lamp_pin_o = (lamp_oe_i & lamp_i) | (~lamp_oe_i & pull_up_i);
  // Sleep pins idle high; the board or the device may sink them.
  assign sleep_pin_o = ~(sleep_oe_i | sleep_low_i);
  // Only a fitted pull-up reads as one; an open strap sits on its pull-down.
  assign strap_o = fit_i;
endmodule : led_strap_board

/* File: test/led_strap_reset_control_properties.sv */
// Assertions on the bus, lamp, sleep pin and address ports.
`timescale 1ns/10ps
module led_strap_props
  import led_strap_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input port_status_t port_a_status_i,
  input logic port_a_speed_lamp_o,
  input logic port_a_speed_lamp_oe_o,
  input logic port_a_sleep_irq_pin_i,
  input logic port_a_sleep_irq_pin_o,
  input logic port_a_sleep_irq_pin_oe_o,
  input logic [1:0] irq_cond_i,
  input logic [1:0] sleep_o,
  input logic [4:0] port_a_addr_o,
  input logic [4:0] port_b_addr_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_speed_follow: assert property (
    port_a_speed_lamp_oe_o && $past(port_a_speed_lamp_oe_o) && $past(port_a_speed_lamp_oe_o, 2)
    |-> $changed(port_a_speed_lamp_o) == $changed($past(port_a_status_i.speed_100)))
    else $error("speed lamp wrong");
  a_open_drain: assert property (!port_a_sleep_irq_pin_o)
    else $error("sleep pin driven high");
  a_irq_pin: assert property (port_a_sleep_irq_pin_oe_o |-> $past(irq_cond_i[0]))
    else $error("sleep pin sunk idly");
  a_sleep_enter: assert property (
    (!port_a_sleep_irq_pin_oe_o && !port_a_sleep_irq_pin_i) [*8] |-> sleep_o[0])
    else $error("no power-down");
  a_sleep_exit: assert property (port_a_sleep_irq_pin_i [*8] |-> !sleep_o[0])
    else $error("stray power-down");
  a_addr_pair: assert property (
    !port_a_addr_o[0] && port_b_addr_o == {port_a_addr_o[4:1], 1'h1})
    else $error("addresses unpaired");
endmodule : led_strap_props
bind led_strap_reset_control led_strap_props chk (.*);

/* File: test/led_strap_reset_control_tb.sv */
// Self-checking bench for the lamp, strap, reset and sleep pin block.
`timescale 1ns/10ps
`include "led_strap_params.svh"
module led_strap_reset_control_tb;
  import led_strap_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, board_reset_n_i;
  logic led_mode_strap_i, addr_strap_bit1_i, addr_strap_bit2_i, addr_strap_bit3_i;
  logic addr_strap_bit4_i, sw0, sw1;
  logic [7:0] wb_adr_i;
  logic [7:0] zad [3] = '{`OFS_CTRL, `OFS_MASK, 8'h10};
  logic [3:0] wb_sel_i, fit;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  port_status_t port_a_status_i, port_b_status_i, a, b;
  logic [1:0] irq_cond_i, sleep_o, s_oe, s_low, s_pin;
  logic [4:0] port_a_addr_o, port_b_addr_o;
  logic [5:0] lo, loe, pu, pin;
  int mismatches, num_checks;
  led_strap_reset_control #(.BLINK_HALF_CYCLES(4)) uut (.*,
    .port_a_link_lamp_i(pin[0]), .port_a_link_lamp_o(lo[0]), .port_a_link_lamp_oe_o(loe[0]),
    .port_a_speed_lamp_i(pin[1]), .port_a_speed_lamp_o(lo[1]), .port_a_speed_lamp_oe_o(loe[1]),
    .port_a_activity_collision_lamp_i(pin[2]), .port_a_activity_collision_lamp_o(lo[2]),
    .port_a_activity_collision_lamp_oe_o(loe[2]),
    .port_b_link_lamp_i(pin[3]), .port_b_link_lamp_o(lo[3]), .port_b_link_lamp_oe_o(loe[3]),
    .port_b_speed_lamp_i(pin[4]), .port_b_speed_lamp_o(lo[4]), .port_b_speed_lamp_oe_o(loe[4]),
    .port_b_activity_collision_lamp_i(pin[5]), .port_b_activity_collision_lamp_o(lo[5]),
    .port_b_activity_collision_lamp_oe_o(loe[5]),
    .port_a_sleep_irq_pin_i(s_pin[0]), .port_a_sleep_irq_pin_o(),
    .port_a_sleep_irq_pin_oe_o(s_oe[0]), .port_b_sleep_irq_pin_i(s_pin[1]),
    .port_b_sleep_irq_pin_o(), .port_b_sleep_irq_pin_oe_o(s_oe[1]));
  led_strap_board board (.lamp_i(lo), .lamp_oe_i(loe), .pull_up_i(pu), .lamp_pin_o(pin),
    .sleep_oe_i(s_oe), .sleep_low_i(s_low), .sleep_pin_o(s_pin), .fit_i(fit),
    .strap_o({addr_strap_bit4_i, addr_strap_bit3_i, addr_strap_bit2_i, addr_strap_bit1_i}));
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // Starting on an edge also keeps cyc low for a cycle between accesses.
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      mismatches++;
      end_sim();
    end
  endtask : wb
  task automatic regs0;
    foreach (zad[i]) begin
      wb(1'h0, zad[i], 32'h0, 4'hf);
      check("reset value", rd, 32'h0);
    end
  endtask : regs0
  function automatic logic [31:0] pcr(logic [2:0] m);
    pcr = {6'h00, pu, 1'h0, m, 3'h0, fit, 1'h1, 3'h0, fit, 1'h0};
  endfunction : pcr
  function automatic logic [2:0] lit(port_status_t s, logic m1, logic du);
    lit = {m1 ? s.tx_act | s.rx_act : du ? s.full_duplex : s.collision, s.speed_100, s.link_good};
  endfunction : lit
  // Without mode 1 activity is held off, since a blinking link lamp has no single level.
  task automatic lamps(input logic m1, input logic [1:0] du);
    repeat (12) begin
      @(posedge clk_i);
      a = port_status_t'($urandom & (m1 ? 6'h3f : 6'h33));
      b = port_status_t'($urandom & (m1 ? 6'h3f : 6'h33));
      port_a_status_i <= a;
      port_b_status_i <= b;
      repeat (2) @(posedge clk_i);
      #1;
      check("lamps", pin, {lit(b, m1, du[1]), lit(a, m1, du[0])} ^ pu);
    end
  endtask : lamps
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    void'($urandom(88608));
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {port_a_status_i, port_b_status_i, irq_cond_i, s_low} = '0;
    board_reset_n_i = 1'h1;
    led_mode_strap_i = 1'h1;
    pu = 6'($urandom);
    fit = 4'($urandom);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    check("addr", {port_b_addr_o, port_a_addr_o}, {fit, 1'h1, fit, 1'h0});
    wb(1'h0, `OFS_PORT_CONTROL, 32'h0, 4'hf);
    check("port control", rd, pcr(3'h1));
    wb(1'h1, 8'h10, 32'hffffffff, 4'hf);
    wb(1'h1, `OFS_CTRL, 32'h7f, 4'h0);
    regs0();
    $display("test registers done");
    lamps(1'h1, 2'h0);
    wb(1'h1, `OFS_CTRL, 32'h03, 4'h1);
    wb(1'h1, `OFS_MASK, 32'h1f, 4'h1);
    wb(1'h0, `OFS_PORT_CONTROL, 32'h0, 4'hf);
    check("mode", rd[18:16], 3'h4);
    lamps(1'h0, 2'h1);
    port_a_status_i <= 6'h05;
    sw0 = 1'h0;
    sw1 = 1'h0;
    repeat (16) begin
      @(posedge clk_i);
      #1;
      if (pin[0] ^ pu[0]) sw1 = 1'h1;
      else sw0 = 1'h1;
    end
    check("blink", {sw1, sw0}, 2'h3);
    $display("test lamp modes done");
    led_mode_strap_i <= 1'h0;
    pu <= ~pu;
    fit <= 4'h0;
    board_reset_n_i <= 1'h0;
    repeat (130) @(posedge clk_i);
    board_reset_n_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    regs0();
    wb(1'h0, `OFS_PORT_CONTROL, 32'h0, 4'hf);
    check("restrap", rd, pcr(3'h2));
    fit <= 4'h9;
    repeat (3) @(posedge clk_i);
    check("addr held", port_b_addr_o, 5'h01);
    wb(1'h1, `OFS_CTRL, 32'h06, 4'h1);
    lamps(1'h0, 2'h0);
    $display("test board reset done");
    wb(1'h1, `OFS_MASK, 32'h04, 4'h1);
    wb(1'h0, `OFS_STATUS, 32'h0, 4'hf);
    s_low <= 2'h1;
    repeat (10) @(posedge clk_i);
    check("sleep irq", {irq_o, sleep_o}, 3'h5);
    wb(1'h0, `OFS_STATUS, 32'h0, 4'hf);
    check("sleep event", rd[2], 1'h1);
    s_low <= 2'h3;
    repeat (10) @(posedge clk_i);
    check("irq masked", {irq_o, sleep_o}, 3'h3);
    s_low <= 2'h0;
    wb(1'h1, `OFS_CTRL, 32'h28, 4'h1);
    irq_cond_i <= 2'h3;
    repeat (3) @(posedge clk_i);
    check("irq pin", s_pin, 2'h2);
    irq_cond_i <= 2'h0;
    repeat (3) @(posedge clk_i);
    check("irq pin idle", s_pin, 2'h3);
    wb(1'h1, `OFS_CTRL, 32'h50, 4'h1);
    irq_cond_i <= 2'h3;
    repeat (3) @(posedge clk_i);
    check("irq pin b", s_pin, 2'h1);
    irq_cond_i <= 2'h0;
    $display("test sleep and interrupt done");
    end_sim();
  end
endmodule : led_strap_reset_control_tb
